// *** sfr_pkg.sv ***
// special function register bank: offsets, bit positions and reset values
package sfr_pkg;
   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam logic [15:0] SFR_LAST_ADDR = 16'h000F;
   localparam logic [15:0] IRQ_ENABLE_ONE_ADDR = 16'h0000;
   localparam logic [15:0] IRQ_ENABLE_TWO_ADDR = 16'h0001;
   localparam logic [15:0] IRQ_FLAG_ONE_ADDR = 16'h0002;
   localparam logic [15:0] IRQ_FLAG_TWO_ADDR = 16'h0003;
   // ---------------------------------------------------------------
   // enable register fields
   // ---------------------------------------------------------------
   localparam int INTERVAL_TIMER_IRQ_EN_BIT = 0;
   localparam int OSC_FAULT_IRQ_EN_BIT = 1;
   localparam int PIN_NONMASK_IRQ_EN_BIT = 4;
   localparam int FLASH_VIOLATION_IRQ_EN_BIT = 5;
   localparam logic [7:0] IRQ_ENABLE_CLR = 8'h00;
   // ---------------------------------------------------------------
   // flag register fields
   // ---------------------------------------------------------------
   localparam int FLAG_WIDTH = 5;
   localparam int WATCHDOG_EVENT_FLAG_BIT = 0;
   localparam int OSC_FAULT_FLAG_BIT = 1;
   localparam int POWER_UP_FLAG_BIT = 2;
   localparam int EXT_RESET_FLAG_BIT = 3;
   localparam int PIN_NONMASK_FLAG_BIT = 4;
   // power-on values; osc fault and nonmask flags are also forced by power-up clear
   localparam logic [4:0] FLAG_POR_VALUE = 5'h06;
   localparam logic OSC_FAULT_FLAG_CLR = 1'b1;
   localparam logic PIN_NONMASK_FLAG_CLR = 1'b0;
   localparam logic [7:0] READ_IDLE_VALUE = 8'h00;
endpackage

// *** sfr_wr_if.sv ***
// write path from the bus decoder to the flag register
`timescale 1ns/1ns
interface sfr_wr_if;
   logic flag_wr;
   logic [7:0] wdata;
   logic power_up_clear;
   modport src (output flag_wr, output wdata, output power_up_clear);
   modport dst (input flag_wr, input wdata, input power_up_clear);
endinterface

// *** sfr_flag_reg.sv ***
// system flag register: hardware events set, software writes, resets
`timescale 1ns/1ns
module sfr_flag_reg (
   input wire logic clk, // system clock
   input wire logic rst_n, // power-on reset, active low
   sfr_wr_if.dst wr, // write strobe, data and power-up clear
   input wire logic wdt_overflow, // watchdog overflow in watchdog mode
   input wire logic key_violation, // security key violation
   input wire logic osc_fault, // oscillator fault detected
   input wire logic ext_reset, // reset condition on reset pin
   input wire logic nonmask_event, // pin event in nonmaskable mode
   output logic [4:0] flag_q // flag register contents
);
   // ---------------------------------------------------------------
   // next value
   // ---------------------------------------------------------------
   logic [4:0] flag_next;
   logic [4:0] set_v;
   logic [4:0] clr_v;

   always_comb begin
      set_v = '0;
      clr_v = '0;
      set_v[sfr_pkg::WATCHDOG_EVENT_FLAG_BIT] = wdt_overflow | key_violation;
      set_v[sfr_pkg::OSC_FAULT_FLAG_BIT] = osc_fault;
      set_v[sfr_pkg::EXT_RESET_FLAG_BIT] = ext_reset;
      set_v[sfr_pkg::PIN_NONMASK_FLAG_BIT] = nonmask_event;
      clr_v[sfr_pkg::WATCHDOG_EVENT_FLAG_BIT] = ext_reset;
      flag_next = flag_q;
      if (wr.flag_wr) begin
         flag_next = wr.wdata[4:0];
      end
      // events win over software write and over the pin clear
      flag_next = (flag_next & ~clr_v) | set_v;
      if (wr.power_up_clear) begin
         flag_next[sfr_pkg::OSC_FAULT_FLAG_BIT] = sfr_pkg::OSC_FAULT_FLAG_CLR;
         flag_next[sfr_pkg::PIN_NONMASK_FLAG_BIT] = sfr_pkg::PIN_NONMASK_FLAG_CLR;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= sfr_pkg::FLAG_POR_VALUE;
      end else begin
         flag_q <= flag_next;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_wdt_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      (wdt_overflow || key_violation) |=> flag_q[sfr_pkg::WATCHDOG_EVENT_FLAG_BIT])
      else $error("watchdog flag not set by event");
   a_wdt_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (ext_reset && !wdt_overflow && !key_violation)
      |=> !flag_q[sfr_pkg::WATCHDOG_EVENT_FLAG_BIT] && flag_q[sfr_pkg::EXT_RESET_FLAG_BIT])
      else $error("pin reset did not clear watchdog flag and set reset flag");
   a_osc_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      (osc_fault || wr.power_up_clear) |=> flag_q[sfr_pkg::OSC_FAULT_FLAG_BIT])
      else $error("osc fault flag not set");
   a_nonmask_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
      wr.power_up_clear |=> !flag_q[sfr_pkg::PIN_NONMASK_FLAG_BIT])
      else $error("nonmask flag not cleared by power-up clear");
   a_set_beats_write: assert property (@(posedge clk) disable iff (!rst_n)
      (nonmask_event && wr.flag_wr && !wr.wdata[4] && !wr.power_up_clear)
      |=> flag_q[sfr_pkg::PIN_NONMASK_FLAG_BIT])
      else $error("nonmask event lost against software clear");
   a_power_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !wr.flag_wr |=> $stable(flag_q[sfr_pkg::POWER_UP_FLAG_BIT]))
      else $error("power-up flag changed without a write");
endmodule // sfr_flag_reg

// *** sfr_bank.sv ***
// special function register bank: system interrupt enables and flags
//
// Functional notes
// - only defined enable and flag bits exist
// - all defined bits byte read/writable
// - enable register at 00h, cleared by power-up clear
// - watchdog flag set by overflow or key
// - watchdog flag cleared by POR, pin reset
// - osc flag set on fault and POWER_UP_CLEAR
// - power-up flag forced to 1 by POR
// - pin reset sets flag 3; POR clears
// - pin event sets flag 4; clear resets it
// - decode 00h to 0Fh as SFR space
`timescale 1ns/1ns
module sfr_bank (
   input wire logic MCLK, // system clock, 10 MHz
   input wire logic RESETN, // power-on reset, active low
   input wire logic POWER_UP_CLEAR, // power-up clear, one-cycle pulse
   input wire logic [15:0] ADDR, // cpu byte address
   input wire logic [7:0] DIN, // cpu write data
   input wire logic WR, // cpu byte write strobe
   input wire logic RD, // cpu byte read strobe
   output logic [7:0] DOUT, // read data, one cycle after RD
   input wire logic WDT_INTERVAL_MODE, // 1: watchdog runs as interval timer
   input wire logic WDT_OVERFLOW, // watchdog overflow in watchdog mode
   input wire logic KEY_VIOLATION, // security key violation
   input wire logic OSC_FAULT, // oscillator fault detected
   input wire logic EXT_RESET, // reset condition on reset pin
   input wire logic NONMASK_EVENT, // pin event in nonmaskable mode
   output logic INTERVAL_TIMER_IRQ_EN, // effective interval enable
   output logic OSC_FAULT_IRQ_EN, // oscillator fault enable
   output logic PIN_NONMASK_IRQ_EN, // nonmaskable pin enable
   output logic FLASH_VIOLATION_IRQ_EN, // flash violation enable
   output logic [4:0] FLAGS // system flag register
);
   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic logic in_sfr(input logic [15:0] a);
      return a <= sfr_pkg::SFR_LAST_ADDR;
   endfunction

   function automatic logic hits(input logic [15:0] a, input logic [15:0] offs);
      return in_sfr(a) && (a == offs);
   endfunction

   sfr_wr_if wr_bus ();

   logic enable_wr;
   assign enable_wr = WR && hits(ADDR, sfr_pkg::IRQ_ENABLE_ONE_ADDR);
   assign wr_bus.flag_wr = WR && hits(ADDR, sfr_pkg::IRQ_FLAG_ONE_ADDR);
   assign wr_bus.wdata = DIN;
   assign wr_bus.power_up_clear = POWER_UP_CLEAR;

   // ---------------------------------------------------------------
   // enable register
   // ---------------------------------------------------------------
   // four real bits only; the other positions have no storage at all
   logic interval_en_reg;
   logic osc_en_reg;
   logic nonmask_en_reg;
   logic flash_en_reg;

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         interval_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::INTERVAL_TIMER_IRQ_EN_BIT];
         osc_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::OSC_FAULT_IRQ_EN_BIT];
         nonmask_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::PIN_NONMASK_IRQ_EN_BIT];
         flash_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::FLASH_VIOLATION_IRQ_EN_BIT];
      end else if (POWER_UP_CLEAR) begin
         // power-up clear wins over a write in the same cycle
         interval_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::INTERVAL_TIMER_IRQ_EN_BIT];
         osc_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::OSC_FAULT_IRQ_EN_BIT];
         nonmask_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::PIN_NONMASK_IRQ_EN_BIT];
         flash_en_reg <= sfr_pkg::IRQ_ENABLE_CLR[sfr_pkg::FLASH_VIOLATION_IRQ_EN_BIT];
      end else if (enable_wr) begin
         interval_en_reg <= DIN[sfr_pkg::INTERVAL_TIMER_IRQ_EN_BIT];
         osc_en_reg <= DIN[sfr_pkg::OSC_FAULT_IRQ_EN_BIT];
         nonmask_en_reg <= DIN[sfr_pkg::PIN_NONMASK_IRQ_EN_BIT];
         flash_en_reg <= DIN[sfr_pkg::FLASH_VIOLATION_IRQ_EN_BIT];
      end
   end

   // ---------------------------------------------------------------
   // enable outputs
   // ---------------------------------------------------------------
   // registered, so an output lags its register by one cycle
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         INTERVAL_TIMER_IRQ_EN <= 1'b0;
         OSC_FAULT_IRQ_EN <= 1'b0;
         PIN_NONMASK_IRQ_EN <= 1'b0;
         FLASH_VIOLATION_IRQ_EN <= 1'b0;
      end else begin
         INTERVAL_TIMER_IRQ_EN <= interval_en_reg && WDT_INTERVAL_MODE;
         OSC_FAULT_IRQ_EN <= osc_en_reg;
         PIN_NONMASK_IRQ_EN <= nonmask_en_reg;
         FLASH_VIOLATION_IRQ_EN <= flash_en_reg;
      end
   end

   // ---------------------------------------------------------------
   // flag register
   // ---------------------------------------------------------------
   sfr_flag_reg flags_u (
      .clk(MCLK),
      .rst_n(RESETN),
      .wr(wr_bus),
      .wdt_overflow(WDT_OVERFLOW),
      .key_violation(KEY_VIOLATION),
      .osc_fault(OSC_FAULT),
      .ext_reset(EXT_RESET),
      .nonmask_event(NONMASK_EVENT),
      .flag_q(FLAGS)
   );

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [7:0] rd_next;

   always_comb begin
      rd_next = sfr_pkg::READ_IDLE_VALUE;
      if (hits(ADDR, sfr_pkg::IRQ_ENABLE_ONE_ADDR)) begin
         rd_next[sfr_pkg::INTERVAL_TIMER_IRQ_EN_BIT] = interval_en_reg;
         rd_next[sfr_pkg::OSC_FAULT_IRQ_EN_BIT] = osc_en_reg;
         rd_next[sfr_pkg::PIN_NONMASK_IRQ_EN_BIT] = nonmask_en_reg;
         rd_next[sfr_pkg::FLASH_VIOLATION_IRQ_EN_BIT] = flash_en_reg;
      end else if (hits(ADDR, sfr_pkg::IRQ_FLAG_ONE_ADDR)) begin
         rd_next[4:0] = FLAGS;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         DOUT <= sfr_pkg::READ_IDLE_VALUE;
      end else if (RD) begin
         DOUT <= rd_next;
      end else begin
         DOUT <= sfr_pkg::READ_IDLE_VALUE;
      end
   end

   // ---------------------------------------------------------------
   // checks: enable side and read path
   // ---------------------------------------------------------------
   a_enable_write_read: assert property (@(posedge MCLK) disable iff (!RESETN)
      (WR && !POWER_UP_CLEAR && ADDR == sfr_pkg::IRQ_ENABLE_ONE_ADDR) ##1
      (RD && !WR && !POWER_UP_CLEAR && ADDR == sfr_pkg::IRQ_ENABLE_ONE_ADDR)
      |=> DOUT == ($past(DIN, 2) & 8'h33))
      else $error("enable register readback mismatch");
   a_enable_clear_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
      POWER_UP_CLEAR |=> ##1 !OSC_FAULT_IRQ_EN && !PIN_NONMASK_IRQ_EN
      && !FLASH_VIOLATION_IRQ_EN && !INTERVAL_TIMER_IRQ_EN)
      else $error("enables not cleared by power-up clear");
   a_enable_out_follow: assert property (@(posedge MCLK) disable iff (!RESETN)
      (WR && !POWER_UP_CLEAR && ADDR == sfr_pkg::IRQ_ENABLE_ONE_ADDR) |=> ##1
      (OSC_FAULT_IRQ_EN == $past(DIN[sfr_pkg::OSC_FAULT_IRQ_EN_BIT], 2))
      && (PIN_NONMASK_IRQ_EN == $past(DIN[sfr_pkg::PIN_NONMASK_IRQ_EN_BIT], 2))
      && (FLASH_VIOLATION_IRQ_EN == $past(DIN[sfr_pkg::FLASH_VIOLATION_IRQ_EN_BIT], 2)))
      else $error("enable outputs do not follow the written byte");
   a_interval_follow: assert property (@(posedge MCLK) disable iff (!RESETN)
      (WR && !POWER_UP_CLEAR && ADDR == sfr_pkg::IRQ_ENABLE_ONE_ADDR && WDT_INTERVAL_MODE)
      ##1 WDT_INTERVAL_MODE
      |=> INTERVAL_TIMER_IRQ_EN == $past(DIN[sfr_pkg::INTERVAL_TIMER_IRQ_EN_BIT], 2))
      else $error("interval enable does not follow the write in timer mode");
   a_interval_gated: assert property (@(posedge MCLK) disable iff (!RESETN)
      !WDT_INTERVAL_MODE |=> !INTERVAL_TIMER_IRQ_EN)
      else $error("interval enable active in watchdog mode");
   a_enable_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
      (!POWER_UP_CLEAR && !enable_wr)
      |=> $stable({flash_en_reg, nonmask_en_reg, osc_en_reg, interval_en_reg}))
      else $error("enable register changed without a write");
   a_enable_read_data: assert property (@(posedge MCLK) disable iff (!RESETN)
      (RD && ADDR == sfr_pkg::IRQ_ENABLE_ONE_ADDR) |=> DOUT == {2'h0, $past(flash_en_reg),
      $past(nonmask_en_reg), 2'h0, $past(osc_en_reg), $past(interval_en_reg)})
      else $error("enable read data wrong");
   a_dout_idle_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
      !RD |=> DOUT == sfr_pkg::READ_IDLE_VALUE)
      else $error("read data not idle without a read");
   a_reserved_read_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
      (RD && (ADDR == sfr_pkg::IRQ_ENABLE_TWO_ADDR || ADDR == sfr_pkg::IRQ_FLAG_TWO_ADDR))
      |=> DOUT == 8'h00)
      else $error("reserved address read nonzero");
   a_outside_read_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
      (RD && ADDR > sfr_pkg::SFR_LAST_ADDR) |=> DOUT == 8'h00)
      else $error("address outside bank answered");

   // ---------------------------------------------------------------
   // checks: flag side
   // ---------------------------------------------------------------
   a_flag_high_bits_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
      (RD && ADDR == sfr_pkg::IRQ_FLAG_ONE_ADDR) |=> DOUT[7:5] == 3'h0
      && DOUT[4:0] == $past(FLAGS))
      else $error("flag read wrong");
   a_flag_write_lands: assert property (@(posedge MCLK) disable iff (!RESETN)
      (WR && !POWER_UP_CLEAR && ADDR == sfr_pkg::IRQ_FLAG_ONE_ADDR && !WDT_OVERFLOW
      && !KEY_VIOLATION && !OSC_FAULT && !EXT_RESET && !NONMASK_EVENT)
      |=> FLAGS == $past(DIN[4:0]))
      else $error("flag write did not land");
   a_flag_ignores_other: assert property (@(posedge MCLK) disable iff (!RESETN)
      (!(WR && ADDR == sfr_pkg::IRQ_FLAG_ONE_ADDR) && !POWER_UP_CLEAR && !WDT_OVERFLOW
      && !KEY_VIOLATION && !OSC_FAULT && !EXT_RESET && !NONMASK_EVENT)
      |=> $stable(FLAGS))
      else $error("flags changed without a cause");
   a_key_flag_set: assert property (@(posedge MCLK) disable iff (!RESETN)
      KEY_VIOLATION |=> FLAGS[sfr_pkg::WATCHDOG_EVENT_FLAG_BIT])
      else $error("key violation did not set the watchdog flag");
   a_ext_flag_set: assert property (@(posedge MCLK) disable iff (!RESETN)
      EXT_RESET |=> FLAGS[sfr_pkg::EXT_RESET_FLAG_BIT])
      else $error("pin reset did not set its flag");
   a_nonmask_flag_set: assert property (@(posedge MCLK) disable iff (!RESETN)
      (NONMASK_EVENT && !POWER_UP_CLEAR) |=> FLAGS[sfr_pkg::PIN_NONMASK_FLAG_BIT])
      else $error("nonmask event did not set its flag");
   a_clear_flag_bits: assert property (@(posedge MCLK) disable iff (!RESETN)
      POWER_UP_CLEAR |=> FLAGS[sfr_pkg::OSC_FAULT_FLAG_BIT]
      && !FLAGS[sfr_pkg::PIN_NONMASK_FLAG_BIT])
      else $error("power-up clear left osc or nonmask flag wrong");
   a_clear_keeps_rest: assert property (@(posedge MCLK) disable iff (!RESETN)
      (POWER_UP_CLEAR && !(WR && ADDR == sfr_pkg::IRQ_FLAG_ONE_ADDR) && !WDT_OVERFLOW
      && !KEY_VIOLATION && !EXT_RESET)
      |=> $stable({FLAGS[sfr_pkg::EXT_RESET_FLAG_BIT], FLAGS[sfr_pkg::POWER_UP_FLAG_BIT],
      FLAGS[sfr_pkg::WATCHDOG_EVENT_FLAG_BIT]}))
      else $error("power-up clear touched a power-on flag");
endmodule // sfr_bank

// *** sfr_cpu_model.sv ***
// bus master model: byte writes and reads on the register bus
`timescale 1ns/1ns
module sfr_cpu_model (
   input wire logic clk, // system clock
   output logic [15:0] addr, // byte address
   output logic [7:0] din, // write data
   output logic wr, // write strobe
   output logic rd, // read strobe
   input wire logic [7:0] dout // registered read data
);
   initial begin
      addr = 16'h0000;
      din = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // strobe held across one rising edge, then dropped
   task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      din = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      din = ~d; // released data must not look like the last value
   endtask
   // data sampled after the edge that took the read
   task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = dout;
   endtask
   // write then read in the very next cycle, no idle cycle between
   task automatic wr_rd_byte(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge clk);
      addr = a;
      din = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      din = ~d;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      q = dout;
   endtask
endmodule // sfr_cpu_model

// *** sfr_bank_tb_top.sv ***
// self-checking bench for the special function register bank
`timescale 1ns/1ns
module sfr_bank_tb_top;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic clear_req = 1'b0;
   logic mode = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [15:0] addr;
   logic [7:0] din;
   logic [7:0] dout;
   logic wr;
   logic rd;
   logic [3:0] en;
   logic [4:0] flags;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   always #50 mclk = ~mclk;
   sfr_cpu_model sfr_cpu_model_inst (.clk(mclk), .addr(addr), .din(din), .wr(wr),
      .rd(rd), .dout(dout));
   sfr_bank sfr_bank_inst (.MCLK(mclk), .RESETN(resetn), .POWER_UP_CLEAR(clear_req),
      .ADDR(addr), .DIN(din), .WR(wr), .RD(rd), .DOUT(dout), .WDT_INTERVAL_MODE(mode),
      .WDT_OVERFLOW(ev[0]), .KEY_VIOLATION(ev[1]), .OSC_FAULT(ev[2]),
      .EXT_RESET(ev[3]), .NONMASK_EVENT(ev[4]), .INTERVAL_TIMER_IRQ_EN(en[0]),
      .OSC_FAULT_IRQ_EN(en[1]), .PIN_NONMASK_IRQ_EN(en[2]),
      .FLASH_VIOLATION_IRQ_EN(en[3]), .FLAGS(flags));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      sfr_cpu_model_inst.rd_byte(a, d);
      chk($sformatf("read %h", a), exp, d);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(negedge mclk);
      ev = v;
      @(negedge mclk);
      ev = 5'h00;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset_values;
      chk("flags port", 8'h06, {3'h0, flags});
      chk("enable outputs", 8'h00, {4'h0, en});
      rd_chk(16'h0000, 8'h00);
      rd_chk(16'h0002, 8'h06);
   endtask
   task automatic t_enable_rw;
      logic [7:0] d;
      sfr_cpu_model_inst.wr_byte(16'h0000, 8'hFF);
      rd_chk(16'h0000, 8'h33);
      chk("enables timer off", 8'h0E, {4'h0, en});
      mode = 1'b1;
      repeat (2) @(negedge mclk);
      chk("enables timer on", 8'h0F, {4'h0, en});
      sfr_cpu_model_inst.wr_byte(16'h0000, 8'h32);
      rd_chk(16'h0000, 8'h32);
      chk("enables timer write", 8'h0E, {4'h0, en});
      mode = 1'b0;
      sfr_cpu_model_inst.wr_rd_byte(16'h0000, 8'h21, d);
      chk("read 0000 after write", 8'h21, d);
      chk("enables partial", 8'h08, {4'h0, en});
   endtask
   task automatic t_unmapped;
      logic [15:0] a [6] = '{16'h0001, 16'h0003, 16'h0004, 16'h000F, 16'h0010, 16'h01FF};
      foreach (a[i]) begin
         sfr_cpu_model_inst.wr_byte(a[i], 8'hFF);
         rd_chk(a[i], 8'h00);
      end
      rd_chk(16'h0000, 8'h21);
      rd_chk(16'h0002, 8'h06);
   endtask
   task automatic t_flag_rw;
      sfr_cpu_model_inst.wr_byte(16'h0002, 8'hFF);
      rd_chk(16'h0002, 8'h1F);
      sfr_cpu_model_inst.wr_byte(16'h0002, 8'h00);
      rd_chk(16'h0002, 8'h00);
   endtask
   task automatic t_events;
      logic [7:0] exp [5] = '{8'h01, 8'h01, 8'h02, 8'h08, 8'h10};
      for (int i = 0; i < 5; i++) begin
         sfr_cpu_model_inst.wr_byte(16'h0002, 8'h00);
         pulse(5'h01 << i);
         chk("flags after event", exp[i], {3'h0, flags});
      end
      sfr_cpu_model_inst.wr_byte(16'h0002, 8'h00);
      pulse(5'h01);
      pulse(5'h08);
      rd_chk(16'h0002, 8'h08);
      // software clear and pin event at the same edge
      fork
         sfr_cpu_model_inst.wr_byte(16'h0002, 8'h00);
         pulse(5'h10);
      join
      chk("event beats write", 8'h10, {3'h0, flags});
   endtask
   task automatic t_power_up_clear;
      sfr_cpu_model_inst.wr_byte(16'h0000, 8'hFF);
      sfr_cpu_model_inst.wr_byte(16'h0002, 8'h1D);
      @(negedge mclk);
      clear_req = 1'b1;
      @(negedge mclk);
      clear_req = 1'b0;
      rd_chk(16'h0000, 8'h00);
      rd_chk(16'h0002, 8'h0F);
      chk("enables after clear", 8'h00, {4'h0, en});
   endtask
   task automatic t_power_on;
      sfr_cpu_model_inst.wr_byte(16'h0000, 8'hFF);
      @(negedge mclk);
      resetn = 1'b0;
      repeat (2) @(negedge mclk);
      chk("flags in reset", 8'h06, {3'h0, flags});
      chk("enables in reset", 8'h00, {4'h0, en});
      resetn = 1'b1;
      rd_chk(16'h0002, 8'h06);
      rd_chk(16'h0000, 8'h00);
   endtask
   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         $display("[FAIL] run length expected below 2000 cycles seen %0d", cycles);
         finish_test();
      end
   end
   initial begin
      repeat (4) @(negedge mclk);
      resetn = 1'b1;
      t_reset_values();
      t_enable_rw();
      t_unmapped();
      t_flag_rw();
      t_events();
      t_power_up_clear();
      t_power_on();
      finish_test();
   end
endmodule // sfr_bank_tb_top
